// file: hdl/port_address_config_loader.sv
// Purpose: control block decode, eeprom programming and port decode load
// Assumes: host drives a10..a0 with one-cycle rd/wr strobes on i_sys_clk
// Notes:   uart register sets themselves live outside this block
//          a control block hit beats a port hit at the same address
//          a load walks locations 1..d at two clocks each
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - port bases span 100 to 3f8 hex
// - control block from jumpers, ports from eeprom
// - sharing register placed relative to channel a
// - stored byte is base/8, compared a9..a3
// - absent jumper one, fitted jumper zero
// - jumpers weigh 200,100,80,40,20 hex
// - low address lines select inner registers
// - data write stores at selected location
// - offset 3 write reloads all entries
// - same load runs after power-on
// - locations 1..8 hold channel a..h bases
// - 9..c irq a..d, d shared e..h
// - disable jumper hides ports, keeps control
// - jumper removed: ports at loaded addresses
// - only irq 2,3,5,7,10,11 routable
// - status register at channel a plus 400
module port_address_config_loader #(
    parameter int unsigned NUM_CHAN  = port_cfg_pkg::NUM_CHAN,
    parameter int unsigned WRITE_CYC = port_cfg_pkg::EE_WRITE_CYC
) (
    input  wire logic                        i_sys_clk,
    input  wire logic                        i_rst,
    input  wire logic                        i_ce,
    input  wire port_cfg_pkg::io_req_s       i_io,
    input  wire logic [10:10]                i_addr_hi,
    input  wire logic [4:0]                  i_addr_jumper_n,
    input  wire logic                        i_port_disable_jumper_n,
    output logic                             o_ctrl_sel,
    output logic [7:0]                       o_rdata,
    output logic                             o_rdata_oe,
    output port_cfg_pkg::port_sel_s          o_port_sel [NUM_CHAN],
    output logic                             o_status_sel,
    output logic [3:0]                       o_chan_irq [NUM_CHAN],
    output logic                             o_loading,
    output logic                             o_loaded
);
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ADDR  = 4'b0010,
        ST_CATCH = 4'b0100,
        ST_DONE  = 4'b1000
    } load_state_e;

    // pin synchronisers: three stages, change taken once stages two and three agree
    logic [4:0] jmp_s1_reg, jmp_s2_reg, jmp_s3_reg, jmp_reg;
    logic       dis_s1_reg, dis_s2_reg, dis_s3_reg, dis_reg;

    // reset reads every jumper absent and the disable jumper fitted, so ports start hidden
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            jmp_s1_reg <= 5'h1f;
            jmp_s2_reg <= 5'h1f;
            jmp_s3_reg <= 5'h1f;
            jmp_reg    <= 5'h1f;
            dis_s1_reg <= 1'b0;
            dis_s2_reg <= 1'b0;
            dis_s3_reg <= 1'b0;
            dis_reg    <= 1'b0;
        end else if (i_ce) begin
            jmp_s1_reg <= i_addr_jumper_n;
            jmp_s2_reg <= jmp_s1_reg;
            jmp_s3_reg <= jmp_s2_reg;
            // whole-vector agreement: a half-moved jumper set is never decoded
            if (jmp_s2_reg == jmp_s3_reg) begin
                jmp_reg <= jmp_s3_reg;
            end
            dis_s1_reg <= i_port_disable_jumper_n;
            dis_s2_reg <= dis_s1_reg;
            dis_s3_reg <= dis_s2_reg;
            if (dis_s2_reg == dis_s3_reg) begin
                dis_reg <= dis_s3_reg;
            end
        end
    end

    // control block decode: open jumper reads 1, matched to a9..a5
    logic ctrl_hit;
    logic [4:0] ctrl_ofs;
    assign ctrl_hit = (i_addr_hi == 1'b0) &&
                      (i_io.addr[9:port_cfg_pkg::CTRL_SHIFT] == jmp_reg);
    assign ctrl_ofs = i_io.addr[4:0];
    assign o_ctrl_sel = ctrl_hit;

    // one decoder for every control block strobe keeps the offset map in one place
    logic loc_wr;
    logic loc_rd;
    logic ee_wr;
    logic load_req;
    always_comb begin
        loc_wr   = 1'b0;
        loc_rd   = 1'b0;
        ee_wr    = 1'b0;
        load_req = 1'b0;
        if (ctrl_hit) begin
            case (ctrl_ofs)
                port_cfg_pkg::OFS_LOC_SELECT: begin
                    loc_wr = i_io.wr;
                    loc_rd = i_io.rd;
                end
                port_cfg_pkg::OFS_WRITE_DATA: begin
                    ee_wr = i_io.wr;
                end
                port_cfg_pkg::OFS_LOAD_TRIG: begin
                    load_req = i_io.wr;
                end
                default: begin
                    // offset 0 and 4..31 are reserved: reads float, writes vanish
                    loc_rd = 1'b0;
                end
            endcase
        end
    end

    // location select register, readable back
    logic [7:0] loc_sel_reg;
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            loc_sel_reg <= 8'h00;
        end else if (i_ce && loc_wr) begin
            loc_sel_reg <= i_io.wdata;
        end
    end

    // reads: only the location select answers; other offsets float the data bus
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_rdata    <= 8'h00;
            o_rdata_oe <= 1'b0;
        end else if (i_ce) begin
            o_rdata_oe <= loc_rd;
            // data follows the location select every cycle; only the enable marks a read
            o_rdata    <= loc_sel_reg;
        end
    end

    // loader walks locations 1..d, one byte per two cycles
    load_state_e state_reg;
    logic [3:0]  loc_reg;
    logic [7:0]  ee_rdata;
    logic        ee_busy;
    logic        pend_reg;
    logic [3:0]  rd_loc;

    assign rd_loc = loc_reg;

    logic walk_last;
    assign walk_last = (loc_reg == port_cfg_pkg::LOC_LAST);

    // the write port takes the low four bits of the select; higher bits are ignored
    cfg_eeprom #(
        .WRITE_CYC (WRITE_CYC)
    ) u_store (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_wr      (ee_wr),
        .i_waddr   (loc_sel_reg[3:0]),
        .i_wdata   (i_io.wdata),
        .i_raddr   (rd_loc),
        .o_rdata   (ee_rdata),
        .o_busy    (ee_busy)
    );

    // pending load: set by trigger or power-on, wins over the clear at start
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            pend_reg <= 1'b1;
        end else if (i_ce) begin
            if (load_req) begin
                pend_reg <= 1'b1;
            end else if (state_reg == ST_IDLE && !ee_busy) begin
                pend_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_reg <= ST_IDLE;
            loc_reg   <= port_cfg_pkg::LOC_ADDR_FIRST;
        end else if (i_ce) begin
            case (state_reg)
                ST_IDLE: begin
                    // waits out an eeprom write so the load never sees a half-written cell
                    if (pend_reg && !ee_busy) begin
                        state_reg <= ST_ADDR;
                        loc_reg   <= port_cfg_pkg::LOC_ADDR_FIRST;
                    end
                end
                ST_ADDR: begin
                    // the store's read port needs this cycle to present the addressed byte
                    state_reg <= ST_CATCH;
                end
                ST_CATCH: begin
                    if (walk_last) begin
                        state_reg <= ST_DONE;
                    end else begin
                        loc_reg   <= loc_reg + 4'h1;
                        state_reg <= ST_ADDR;
                    end
                end
                ST_DONE: begin
                    // one closing cycle, in which the loaded flag is set
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // loading stays high from the first address cycle to the closing cycle
    assign o_loading = (state_reg != ST_IDLE);

    // stays set through later reloads, so ports keep answering while a reload walks
    logic loaded_reg;
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            loaded_reg <= 1'b0;
        end else if (i_ce && state_reg == ST_DONE) begin
            loaded_reg <= 1'b1;
        end
    end
    assign o_loaded = loaded_reg;

    // only bits 6..0 of a loaded byte count; a base below 100 hex never decodes, so it cannot shadow system devices
    function automatic logic base_in_span(input logic [6:0] b);
        logic [9:0] a;
        a = {b, 3'h0};
        return (a >= port_cfg_pkg::PORT_MIN) && (a <= port_cfg_pkg::PORT_MAX);
    endfunction

    logic capture;
    assign capture = i_ce && state_reg == ST_CATCH;

    // working decode registers
    logic [6:0] base_reg [NUM_CHAN];
    logic [3:0] irq_reg  [port_cfg_pkg::NUM_IRQ_SLOT];

    genvar g;
    generate
        for (g = 0; g < NUM_CHAN; g++) begin : g_chan
            localparam logic [3:0] MY_LOC = 4'(port_cfg_pkg::LOC_ADDR_FIRST + g);
            // channels past the fourth all take the last, shared slot
            localparam int unsigned IRQ_SLOT = (g < port_cfg_pkg::NUM_IRQ_SLOT - 1) ?
                                               g : port_cfg_pkg::NUM_IRQ_SLOT - 1;
            logic in_range;
            logic match;

            always_ff @(posedge i_sys_clk) begin
                if (i_rst) begin
                    // zero lies below the legal span, so a reset channel decodes nowhere
                    base_reg[g] <= 7'h00;
                end else if (capture && loc_reg == MY_LOC) begin
                    base_reg[g] <= ee_rdata[6:0];
                end
            end

            assign in_range = base_in_span(base_reg[g]);
            assign match = (i_addr_hi == 1'b0) &&
                           (i_io.addr[9:port_cfg_pkg::PORT_SHIFT] == base_reg[g]);
            // the control block wins so it stays reachable over a misloaded port
            assign o_port_sel[g].hit = match && in_range && dis_reg && loaded_reg
                                       && !ctrl_hit;
            assign o_port_sel[g].reg_sel = i_io.addr[2:0];
            assign o_chan_irq[g] = irq_reg[IRQ_SLOT];
        end

        for (g = 0; g < port_cfg_pkg::NUM_IRQ_SLOT; g++) begin : g_irq
            localparam logic [3:0] MY_LOC = 4'(port_cfg_pkg::LOC_IRQ_FIRST + g);
            always_ff @(posedge i_sys_clk) begin
                if (i_rst) begin
                    irq_reg[g] <= port_cfg_pkg::IRQ_NONE;
                end else if (capture && loc_reg == MY_LOC) begin
                    // a level outside the routable set leaves the channel unrouted
                    if (ee_rdata[7:4] == 4'h0 &&
                        port_cfg_pkg::IRQ_LEGAL_MASK[ee_rdata[3:0]]) begin
                        irq_reg[g] <= ee_rdata[3:0];
                    end else begin
                        irq_reg[g] <= port_cfg_pkg::IRQ_NONE;
                    end
                end
            end
        end
    endgenerate

    // status register answers at channel a base plus 400 hex
    assign o_status_sel = (i_addr_hi == 1'b1) &&
                          (i_io.addr[9:port_cfg_pkg::PORT_SHIFT] == base_reg[0]) &&
                          base_in_span(base_reg[0]) && dis_reg && loaded_reg;
endmodule // port_address_config_loader
`default_nettype wire

// file: hdl/port_cfg_pkg.sv
// Purpose: shared constants and types for the port address configuration loader
// Assumes: isa-style i/o bus, 10-bit decoded address, byte-wide data
// Notes:   offsets are byte offsets inside the decoded blocks
package port_cfg_pkg;
    localparam int unsigned NUM_CHAN        = 8;
    localparam int unsigned NUM_IRQ_SLOT    = 5;
    localparam int unsigned ADDR_W          = 10;
    localparam int unsigned ROM_DEPTH       = 16;
    localparam int unsigned ROM_AW          = 4;
    // control block register offsets (a4..a0)
    localparam logic [4:0]  OFS_LOC_SELECT  = 5'h01;
    localparam logic [4:0]  OFS_WRITE_DATA  = 5'h02;
    localparam logic [4:0]  OFS_LOAD_TRIG   = 5'h03;
    // eeprom map
    localparam logic [3:0]  LOC_ADDR_FIRST  = 4'h1;
    localparam logic [3:0]  LOC_IRQ_FIRST   = 4'h9;
    localparam logic [3:0]  LOC_IRQ_SHARED  = 4'hd;
    localparam logic [3:0]  LOC_LAST        = 4'hd;
    // port decode: byte compares a9..a3
    localparam int unsigned PORT_SHIFT      = 3;
    localparam int unsigned CTRL_SHIFT      = 5;
    // status register alias offset above channel a
    localparam logic [10:0] STATUS_ALIAS    = 11'h400;
    localparam logic [9:0]  PORT_MIN        = 10'h100;
    localparam logic [9:0]  PORT_MAX        = 10'h3f8;
    // legal interrupt levels, one bit per level number
    localparam logic [15:0] IRQ_LEGAL_MASK  = 16'h0cac;
    localparam logic [3:0]  IRQ_NONE        = 4'h0;
    // eeprom write cycle time and its cycle count at 100 mhz
    localparam int unsigned CLK_MHZ         = 100;
    localparam int unsigned EE_WRITE_NS     = 100;
    localparam int unsigned EE_WRITE_CYC    = (EE_WRITE_NS * CLK_MHZ + 999) / 1000;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              rd;
        logic              wr;
        logic [7:0]        wdata;
    } io_req_s;

    typedef struct packed {
        logic       hit;
        logic [2:0] reg_sel;
    } port_sel_s;
endpackage

// file: hdl/cfg_eeprom.sv
// Purpose: on-board configuration store with write busy time
// Assumes: single clock, synchronous reset
// Notes:   contents survive reset like a real nonvolatile part
`timescale 1ns/100ps
`default_nettype none
module cfg_eeprom #(
    parameter int unsigned WRITE_CYC = port_cfg_pkg::EE_WRITE_CYC
) (
    input  wire logic                            i_sys_clk,
    input  wire logic                            i_rst,
    input  wire logic                            i_ce,
    input  wire logic                            i_wr,
    input  wire logic [port_cfg_pkg::ROM_AW-1:0] i_waddr,
    input  wire logic [7:0]                      i_wdata,
    input  wire logic [port_cfg_pkg::ROM_AW-1:0] i_raddr,
    output logic      [7:0]                      o_rdata,
    output logic                                 o_busy
);
    logic [7:0]  mem [port_cfg_pkg::ROM_DEPTH];
    logic [15:0] busy_cnt_reg;

    // no reset on the array: the store is nonvolatile
    always_ff @(posedge i_sys_clk) begin
        if (i_ce && i_wr && !o_busy) begin
            mem[i_waddr] <= i_wdata;
        end
        if (i_ce) begin
            o_rdata <= mem[i_raddr];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            busy_cnt_reg <= 16'h0000;
        end else if (i_ce) begin
            if (i_wr && !o_busy) begin
                busy_cnt_reg <= 16'(WRITE_CYC);
            end else if (busy_cnt_reg != 16'h0000) begin
                busy_cnt_reg <= busy_cnt_reg - 16'h0001;
            end
        end
    end

    assign o_busy = (busy_cnt_reg != 16'h0000);
endmodule // cfg_eeprom
`default_nettype wire

// file: testbench/port_cfg_monitor.sv
// Purpose: concurrent checks on the loader's bus-side ports
// Assumes: jumper inputs settle within seven clock cycles
// Notes:   jumper-dependent checks hold off while the synchroniser catches up
`timescale 1ns/100ps
`default_nettype none
module port_cfg_monitor #(
    parameter int unsigned NUM_CHAN = 8
) (
    input wire logic                    i_sys_clk,
    input wire logic                    i_rst,
    input wire logic                    i_ce,
    input wire port_cfg_pkg::io_req_s   i_io,
    input wire logic [10:10]            i_addr_hi,
    input wire logic [4:0]              i_addr_jumper_n,
    input wire logic                    i_port_disable_jumper_n,
    input wire logic                    o_ctrl_sel,
    input wire logic [7:0]              o_rdata,
    input wire logic                    o_rdata_oe,
    input wire port_cfg_pkg::port_sel_s o_port_sel [NUM_CHAN],
    input wire logic                    o_status_sel,
    input wire logic [3:0]              o_chan_irq [NUM_CHAN],
    input wire logic                    o_loading,
    input wire logic                    o_loaded
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst || !i_ce);
    logic [2:0] calm_cnt;
    logic [7:0] loc_reg;
    logic       loc_known;
    wire logic  sel_rd = i_io.rd && o_ctrl_sel && i_io.addr[4:0] == 5'h01;
    wire logic  trig = i_io.wr && o_ctrl_sel && i_io.addr[4:0] == 5'h03;
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || $changed(i_addr_jumper_n) || $changed(i_port_disable_jumper_n))
            calm_cnt <= 3'h0;
        else if (i_ce && calm_cnt != 3'h7)
            calm_cnt <= calm_cnt + 3'h1;
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_rst)
            loc_known <= 1'b0;
        else if (i_ce && i_io.wr && o_ctrl_sel && i_io.addr[4:0] == 5'h01) begin
            loc_known <= 1'b1;
            loc_reg   <= i_io.wdata;
        end
    end
    ctrl_decode_a: assert property (
        calm_cnt == 3'h7 |-> o_ctrl_sel == (!i_addr_hi && i_io.addr[9:5] == i_addr_jumper_n))
        else $error("control block decode mismatch");
    sel_read_a: assert property (
        sel_rd |=> o_rdata_oe && (!loc_known || o_rdata == loc_reg))
        else $error("location select read wrong");
    oe_cause_a: assert property (
        o_rdata_oe |-> $past(sel_rd))
        else $error("read enable without read");
    load_start_a: assert property (trig |-> ##[1:40] o_loading)
        else $error("load trigger ignored");
    load_done_a: assert property ($fell(o_loading) |-> o_loaded)
        else $error("load ended without loaded flag");
    loaded_hold_a: assert property (o_loaded |=> o_loaded)
        else $error("loaded flag dropped");
    shared_irq_a: assert property (
        o_chan_irq[5] == o_chan_irq[4] && o_chan_irq[6] == o_chan_irq[4]
        && o_chan_irq[7] == o_chan_irq[4])
        else $error("shared interrupt differs");
    status_sel_a: assert property (o_status_sel |-> i_addr_hi && o_loaded)
        else $error("status select without alias");
    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
        port_hit_a: assert property (
            o_port_sel[c].hit |-> o_loaded && !o_ctrl_sel && !i_addr_hi
            && i_io.addr >= 10'h100 && o_port_sel[c].reg_sel == i_io.addr[2:0]
            && !(calm_cnt == 3'h7 && !i_port_disable_jumper_n))
            else $error("port hit without cause");
        irq_legal_a: assert property (
            o_chan_irq[c] == 4'h0 || port_cfg_pkg::IRQ_LEGAL_MASK[o_chan_irq[c]])
            else $error("illegal interrupt level routed");
    end
    cover property ($fell(o_loading));
    cover property (o_port_sel[0].hit);
    cover property (o_status_sel);
endmodule // port_cfg_monitor
`default_nettype wire

// file: testbench/io_host_model.sv
// Purpose: host cpu side of the i/o bus
// Assumes: one-cycle strobes launched on falling edges
// Notes:   released data lines show the inverse of the last byte
`timescale 1ns/100ps
`default_nettype none
module io_host_model (
    input  wire logic            i_sys_clk,
    output port_cfg_pkg::io_req_s o_io,
    output logic [10:10]         o_addr_hi
);
    initial begin
        o_io = '0;
        o_addr_hi = 1'b0;
    end
    task automatic cycle(input logic [10:0] a, input logic rd, input logic wr,
                         input logic [7:0] d);
        @(negedge i_sys_clk);
        {o_addr_hi, o_io.addr} = a;
        o_io.rd = rd;
        o_io.wr = wr;
        o_io.wdata = d;
        @(negedge i_sys_clk);
        o_io.rd = 1'b0;
        o_io.wr = 1'b0;
        o_io.wdata = ~d;
    endtask
    // location first, data next, then idle until the store's write time has run out
    task automatic ee_prog(input logic [9:0] ctrl, input logic [3:0] loc,
                           input logic [7:0] d);
        cycle({1'b0, ctrl | 10'h1}, 1'b0, 1'b1, {4'h0, loc});
        cycle({1'b0, ctrl | 10'h2}, 1'b0, 1'b1, d);
        repeat (port_cfg_pkg::EE_WRITE_CYC) @(negedge i_sys_clk);
    endtask
    task automatic probe(input logic [10:0] a);
        @(negedge i_sys_clk);
        {o_addr_hi, o_io.addr} = a;
        #1;
    endtask
endmodule // io_host_model
`default_nettype wire

// file: testbench/testbench.sv
// Purpose: self-checking bench for the port address configuration loader
// Assumes: clock enable held high except for one freeze test
// Notes:   two rounds of programming, second with random bases near the top
`timescale 1ns/100ps
`default_nettype none
bind port_address_config_loader port_cfg_monitor #(.NUM_CHAN(NUM_CHAN)) u_mon (
    .i_sys_clk, .i_rst, .i_ce, .i_io, .i_addr_hi, .i_addr_jumper_n, .i_port_disable_jumper_n,
    .o_ctrl_sel, .o_rdata, .o_rdata_oe, .o_port_sel, .o_status_sel, .o_chan_irq, .o_loading,
    .o_loaded);
module testbench;
    logic                    i_sys_clk = 1'b0;
    logic                    i_rst = 1'b1;
    logic [4:0]              i_addr_jumper_n = 5'h10;
    logic                    i_port_disable_jumper_n = 1'b1;
    logic                    i_ce = 1'b1;
    port_cfg_pkg::io_req_s   i_io;
    logic [10:10]            i_addr_hi;
    logic                    o_ctrl_sel, o_rdata_oe, o_status_sel, o_loading, o_loaded;
    logic [7:0]              o_rdata;
    port_cfg_pkg::port_sel_s o_port_sel [8];
    logic [3:0]              o_chan_irq [8];
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 98;
    int v, k;
    int legal [6] = '{2, 3, 5, 7, 10, 11};
    logic [9:0] ctrl, start;
    logic [9:0] base [8];
    logic [3:0] irq_exp [8];
    logic [7:0] hv;
    always #5 i_sys_clk = ~i_sys_clk;
    port_address_config_loader i_dut (.i_sys_clk, .i_rst, .i_ce, .i_io, .i_addr_hi,
        .i_addr_jumper_n, .i_port_disable_jumper_n, .o_ctrl_sel, .o_rdata, .o_rdata_oe,
        .o_port_sel, .o_status_sel, .o_chan_irq, .o_loading, .o_loaded);
    io_host_model host (.i_sys_clk, .o_io(i_io), .o_addr_hi(i_addr_hi));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wait_load;
        int n;
        n = 0;
        while (o_loading !== 1'b1 && n < 40) begin
            @(negedge i_sys_clk);
            n++;
        end
        check(16'(n < 40), 16'h1);
        while ((o_loading !== 1'b0 || o_loaded !== 1'b1) && n < 240) begin
            @(negedge i_sys_clk);
            n++;
        end
        check(16'(n < 240), 16'h1);
    endtask
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            report_and_stop();
        end
    end
    initial begin
        repeat (4) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        i_rst = 1'b0;
        repeat (6) @(negedge i_sys_clk);
        host.probe(11'h100);
        check(o_port_sel[0].hit, 16'h0);
        wait_load();
        $display("test power-on load done");
        // a frozen block must neither take the write nor answer the read
        i_ce = 1'b0;
        host.cycle(11'h201, 1'b0, 1'b1, 8'h05);
        host.cycle(11'h201, 1'b1, 1'b0, 8'h00);
        check({o_rdata_oe, o_rdata}, 16'h0);
        i_ce = 1'b1;
        $display("test clock enable freeze done");
        for (int r = 0; r < 2; r++) begin
            ctrl = (r == 0) ? 10'h200 : 10'h280;
            i_addr_jumper_n = ctrl[9:5];
            // round 0 programs with the ports hidden
            i_port_disable_jumper_n = (r != 0);
            start = (r == 0) ? 10'h100 : 10'(10'h300 + 8 * ($unsigned($random(seed)) % 25));
            repeat (8) @(negedge i_sys_clk);
            for (int c = 0; c < 8; c++) begin
                base[c] = start + 10'(8 * c);
                host.ee_prog(ctrl, 4'(c + 1), 8'(base[c] >> 3));
            end
            for (int s = 0; s < 5; s++) begin
                v = (r == 1 && s == 0) ? 4 : legal[(s + 3 * r) % 6];
                host.ee_prog(ctrl, 4'(9 + s), 8'(v));
                for (int c = 0; c < 8; c++)
                    if (c == s || (s == 4 && c > 4))
                        irq_exp[c] = (v inside {2, 3, 5, 7, 10, 11}) ? 4'(v) : 4'h0;
            end
            host.cycle({1'b0, ctrl | 10'h1}, 1'b1, 1'b0, 8'h0);
            check({o_rdata_oe, o_rdata}, {1'b1, 8'h0d});
            host.cycle({1'b0, ctrl | 10'h2}, 1'b1, 1'b0, 8'h0);
            check(o_rdata_oe, 16'h0);
            host.cycle({1'b0, ctrl | 10'h3}, 1'b0, 1'b1, 8'($random(seed)));
            wait_load();
            for (int c = 0; c < 8; c++)
                check(o_chan_irq[c], irq_exp[c]);
            host.probe({1'b0, ctrl});
            check(o_ctrl_sel, 16'h1);
            host.probe({1'b0, ctrl + 10'h20});
            check(o_ctrl_sel, 16'h0);
            if (r == 0) begin
                for (int c = 0; c < 8; c++) begin
                    host.probe({1'b0, base[c]});
                    check(o_port_sel[c].hit, 16'h0);
                end
                i_port_disable_jumper_n = 1'b1;
                repeat (8) @(negedge i_sys_clk);
            end
            for (int c = 0; c < 8; c++) begin
                k = $unsigned($random(seed)) % 8;
                host.probe({1'b0, base[c] + 10'(k)});
                for (int d = 0; d < 8; d++)
                    check({o_port_sel[d].hit, o_port_sel[d].reg_sel}, {d == c, 3'(k)});
            end
            host.probe({1'b0, base[0]} | 11'h400);
            check(o_status_sel, 16'h1);
            host.probe({1'b0, base[1]} | 11'h400);
            for (int d = 0; d < 8; d++)
                hv[d] = o_port_sel[d].hit;
            check({o_status_sel, hv}, 16'h0);
            $display("test round %0d done", r);
        end
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
